//--- src/ctlst_consts.svh
// Constants for the controller status bytes block
`ifndef CTLST_CONSTS_SVH
`define CTLST_CONSTS_SVH
// Byte indices of the status bytes in the outgoing frame
`define CTLST_IDX_FIRMWARE     8'h00
`define CTLST_IDX_HARDWARE     8'h01
`define CTLST_IDX_MODEL        8'h02
`define CTLST_IDX_STATE        8'h03
`define CTLST_IDX_WARNINGS     8'h04
// Field positions
`define CTLST_STATE_READY_BIT  0
`define CTLST_FAULT_LSB        4
`define CTLST_WARN_RETAIN_BIT  1
`define CTLST_WARN_SUPPLY_BIT  2
// Reset values
`define CTLST_STATE_RESET      8'h00
`define CTLST_WARN_RESET       8'h00
// Fault codes
`define CTLST_FAULT_NONE       4'h0
`define CTLST_FAULT_DATA_CHECK 4'h2
`define CTLST_FAULT_SHORT      4'h3
`define CTLST_FAULT_MODEL      4'h4
`define CTLST_FAULT_HDR_CHECK  4'h5
`define CTLST_FAULT_SPI_FAST   4'h6
`endif

//--- src/ctlst_pkg.sv
// Types for the controller status bytes block
package ctlst_pkg;
    typedef logic [7:0] ctlst_byte_t;
    typedef logic [3:0] ctlst_fault_t;
    typedef enum logic [1:0] {
        CTLST_IDLE,
        CTLST_FRAME,
        CTLST_SAFE
    } ctlst_state_t;
endpackage

//--- src/ctlst_status.sv
// Controller status bytes served over an SPI mode 0 slave
`timescale 1ns/1ps
`include "ctlst_consts.svh"

module ctlst_status #(
    parameter int          FRAME_BYTES = 67,
    parameter logic [7:0]  FIRMWARE    = 8'h01, // Arbitrary value
    parameter logic [7:0]  HARDWARE    = 8'h01, // Arbitrary value
    parameter logic [7:0]  MODEL_ID    = 8'h41  // Arbitrary value
) (
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 spi_sclk,
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_mosi,
    output logic                      spi_miso,
    output logic                      spi_miso_oe,
    input  wire logic                 device_ready,
    input  wire logic                 safe_state_trip,
    input  wire logic                 data_check_fail,
    input  wire logic                 header_check_fail,
    input  wire logic                 spi_too_fast,
    input  wire ctlst_pkg::ctlst_byte_t host_expected_model_id,
    input  wire logic                 retain_check_warning_flag,
    input  wire logic                 low_supply_warning_flag,
    output ctlst_pkg::ctlst_byte_t    controller_state,
    output ctlst_pkg::ctlst_byte_t    controller_warnings,
    output logic                      frame_done
);
    import ctlst_pkg::*;

    // ========================================================
    // Pin edges
    // ========================================================
    logic         sclk_q;
    logic         cs_n_q;
    logic         rise;
    logic         fall;
    logic         frame_end;
    ctlst_state_t state;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= spi_sclk;
            cs_n_q <= spi_cs_n;
        end
    end

    // Mode 0: sample on rising edge, shift on falling edge
    assign rise      = spi_sclk & ~sclk_q & ~spi_cs_n;
    assign fall      = ~spi_sclk & sclk_q & ~spi_cs_n;
    assign frame_end = spi_cs_n & ~cs_n_q & (state == CTLST_FRAME);

    // ========================================================
    // Frame sequencing
    // ========================================================
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= CTLST_IDLE;
        end else begin
            unique case (state)
                CTLST_IDLE: begin
                    if (safe_state_trip) begin
                        state <= CTLST_SAFE;
                    end else if (~spi_cs_n & cs_n_q) begin
                        state <= CTLST_FRAME;
                    end
                end
                CTLST_FRAME: begin
                    if (safe_state_trip) begin
                        state <= CTLST_SAFE;
                    end else if (spi_cs_n) begin
                        state <= CTLST_IDLE;
                    end
                end
                CTLST_SAFE: state <= CTLST_SAFE;
            endcase
        end
    end

    // ========================================================
    // Bit and byte counters, receive shift
    // ========================================================
    logic [2:0]  bit_cnt;
    logic [7:0]  byte_cnt;
    logic [7:0]  rx_shift;
    logic        model_seen;
    logic        model_bad;
    logic [7:0]  next_rx;

    assign next_rx = {rx_shift[6:0], spi_mosi};

    always_ff @(posedge core_clk) begin
        if (sys_rst || state != CTLST_FRAME) begin
            bit_cnt    <= 3'h0;
            byte_cnt   <= 8'h00;
            rx_shift   <= 8'h00;
            model_seen <= 1'b0;
            model_bad  <= 1'b0;
        end else if (rise) begin
            rx_shift <= next_rx;
            bit_cnt  <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                if (byte_cnt != 8'hff) begin
                    byte_cnt <= byte_cnt + 8'h01;
                end
                // Host sends its expected model at byte 0
                if (byte_cnt == `CTLST_IDX_FIRMWARE) begin
                    model_seen <= 1'b1;
                    model_bad  <= (next_rx != MODEL_ID);
                end
            end
        end
    end

    // ========================================================
    // Status bytes
    // ========================================================
    ctlst_fault_t fault;
    ctlst_fault_t next_fault;
    logic         ready;

    // Priority picks one code when several faults coincide
    always_comb begin
        next_fault = `CTLST_FAULT_NONE;
        if (spi_too_fast) begin
            next_fault = `CTLST_FAULT_SPI_FAST;
        end else if (byte_cnt < 8'(FRAME_BYTES)) begin
            next_fault = `CTLST_FAULT_SHORT;
        end else if (header_check_fail) begin
            next_fault = `CTLST_FAULT_HDR_CHECK;
        end else if ((model_seen && model_bad) ||
                     host_expected_model_id != MODEL_ID) begin
            next_fault = `CTLST_FAULT_MODEL;
        end else if (data_check_fail) begin
            next_fault = `CTLST_FAULT_DATA_CHECK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fault <= `CTLST_FAULT_NONE;
        end else if (frame_end) begin
            fault <= next_fault;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ready <= 1'b0;
        end else if (state == CTLST_SAFE || safe_state_trip) begin
            ready <= 1'b0;
        end else if (frame_end) begin
            ready <= device_ready &&
                     (next_fault == `CTLST_FAULT_NONE);
        end
    end

    // ========================================================
    // Byte assembly
    // ========================================================
    ctlst_byte_t next_state_byte;
    ctlst_byte_t next_warn_byte;

    // Start from the reset value so unassigned bits can only read zero
    always_comb begin
        next_state_byte = `CTLST_STATE_RESET;
        next_state_byte[`CTLST_FAULT_LSB +: 4] = fault;
        next_state_byte[`CTLST_STATE_READY_BIT] = ready;
    end

    always_comb begin
        next_warn_byte = `CTLST_WARN_RESET;
        next_warn_byte[`CTLST_WARN_RETAIN_BIT] =
            retain_check_warning_flag;
        next_warn_byte[`CTLST_WARN_SUPPLY_BIT] =
            low_supply_warning_flag;
    end

    // State byte lands one cycle after the fault and ready registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            controller_state <= `CTLST_STATE_RESET;
        end else begin
            controller_state <= next_state_byte;
        end
    end

    // Flags follow their pins with one cycle of lag, not frame bound
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            controller_warnings <= `CTLST_WARN_RESET;
        end else begin
            controller_warnings <= next_warn_byte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            frame_done <= 1'b0;
        end else begin
            frame_done <= frame_end;
        end
    end

    // ========================================================
    // Transmit shift
    // ========================================================
    function automatic ctlst_byte_t tx_byte(input logic [7:0] idx,
                                            input ctlst_byte_t st,
                                            input ctlst_byte_t wr);
        unique case (idx)
            `CTLST_IDX_FIRMWARE: tx_byte = FIRMWARE;
            `CTLST_IDX_HARDWARE: tx_byte = HARDWARE;
            `CTLST_IDX_MODEL:    tx_byte = MODEL_ID;
            `CTLST_IDX_STATE:    tx_byte = st;
            `CTLST_IDX_WARNINGS: tx_byte = wr;
            default:             tx_byte = 8'h00;
        endcase
    endfunction

    logic [7:0] tx_shift;

    // First bit is valid as soon as select falls, before any edge
    always_ff @(posedge core_clk) begin
        if (sys_rst || state != CTLST_FRAME) begin
            tx_shift <= tx_byte(8'h00, controller_state,
                                controller_warnings);
        end else if (fall) begin
            if (bit_cnt == 3'h0) begin
                tx_shift <= tx_byte(byte_cnt, controller_state,
                                    controller_warnings);
            end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    assign spi_miso    = tx_shift[7];
    // Safe state stops the device answering
    assign spi_miso_oe = ~spi_cs_n & (state == CTLST_FRAME);
endmodule

//--- tb/ctlst_host.sv
// SPI mode 0 host model driving the status block
`timescale 1ns/1ps
module ctlst_host (
    input  wire logic core_clk,
    input  wire logic spi_miso,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Clock stands low between frames; half periods of 4 cycles
    task automatic xfer(input int n, input logic [7:0] b0,
                        output logic [47:0] rx);
        rx = '0;
        @(negedge core_clk);
        spi_cs_n = 1'b0;
        for (int i = 0; i < n * 8; i++) begin
            spi_mosi = (i < 8) ? b0[7 - i] : 1'b0;
            repeat (4) @(negedge core_clk);
            rx = {rx[46:0], spi_miso};
            spi_sclk = 1'b1;
            repeat (4) @(negedge core_clk);
            spi_sclk = 1'b0;
        end
        repeat (4) @(negedge core_clk);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
    endtask
endmodule

//--- tb/ctlst_status_bench.sv
// Testbench for the controller status bytes
`timescale 1ns/1ps
module ctlst_status_bench;
    import ctlst_pkg::*;
    localparam int NB = 6;
    localparam ctlst_byte_t FW = 8'h3c; // Arbitrary value
    localparam ctlst_byte_t HW = 8'h27; // Arbitrary value
    localparam ctlst_byte_t MD = 8'h4d; // Arbitrary value
    localparam logic [2:0] FM [8] = '{3'h1, 3'h2, 3'h0, 3'h0, 3'h4, 3'h7,
                                      3'h0, 3'h0};
    localparam ctlst_fault_t FC [8] = '{4'h2, 4'h5, 4'h4, 4'h3, 4'h6,
                                        4'h6, 4'h4, 4'h0};
    logic        core_clk = 0, sys_rst = 1, mosi, miso, sclk, cs_n, oe;
    logic        rdy = 1, trip = 0, dfail = 0, hfail = 0, fast = 0;
    logic        wret = 0, wlow = 0, frame_done;
    logic [47:0] rx;
    ctlst_byte_t st, wr, exp_st, prev, hmd = MD;
    int          num_errors = 0, num_checks = 0, oe_cnt = 0, n, m;
    // Undriven miso reads as the inverse so a missing enable shows up
    ctlst_host host (.core_clk, .spi_miso(oe ? miso : ~miso),
                     .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi));
    ctlst_status #(.FRAME_BYTES(NB), .FIRMWARE(FW), .HARDWARE(HW),
        .MODEL_ID(MD)) DUT (.core_clk, .sys_rst, .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
        .spi_miso_oe(oe), .device_ready(rdy), .safe_state_trip(trip),
        .data_check_fail(dfail), .header_check_fail(hfail),
        .spi_too_fast(fast), .host_expected_model_id(hmd),
        .retain_check_warning_flag(wret), .low_supply_warning_flag(wlow),
        .controller_state(st), .controller_warnings(wr), .frame_done);
    initial forever #20 core_clk = ~core_clk;
    always @(posedge core_clk) if (oe === 1'b1) oe_cnt++;
    task automatic check(input string what, input ctlst_byte_t e,
                         input ctlst_byte_t g);
        num_checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", what, e, g);
            num_errors++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Bounded wait for the end-of-frame pulse
    task automatic frame(input int nb, input ctlst_byte_t b0);
        int k;
        host.xfer(nb, b0, rx);
        for (k = 0; k < 60 && frame_done !== 1'b1; k++)
            @(negedge core_clk);
        if (k == 60) begin
            check("frame_done", 8'h01, 8'h00);
            tally_and_finish();
        end
        // State byte lands one cycle after the done pulse
        @(negedge core_clk);
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        sys_rst = 0;
        check("state", 8'h00, st);
        check("warnings", 8'h00, wr);
        {wret, wlow} = 2'h3;
        frame(NB, MD);
        check("firmware", FW, rx[47:40]);
        check("hardware", HW, rx[39:32]);
        check("model", MD, rx[31:24]);
        check("state byte", 8'h00, rx[23:16]);
        check("warnings byte", 8'h06, rx[15:8]);
        check("spare byte", 8'h00, rx[7:0]);
        check("state", 8'h01, st);
        check("warnings", 8'h06, wr);
        $display("test bytes done");
        prev = 8'h01;
        for (int i = 0; i < 8; i++) begin
            {fast, hfail, dfail} = FM[i];
            hmd = (i == 6) ? MD ^ 8'h02 : MD;
            n = (i == 3 || i == 5) ? NB - 1 : NB;
            frame(n, MD ^ 8'(i == 2 || i == 5));
            exp_st = {FC[i], 3'h0, FC[i] == 4'h0};
            check("state", exp_st, st);
            check("state byte", prev, rx[8*(n-4)+:8]);
            prev = exp_st;
            {fast, hfail, dfail} = 3'h0;
            hmd = MD;
        end
        $display("test faults done");
        trip = 1;
        repeat (4) @(negedge core_clk);
        m = oe_cnt;
        host.xfer(NB, MD, rx);
        check("oe driven", 8'h00, 8'(oe_cnt != m));
        check("ready", 8'h00, st & 8'h01);
        {sys_rst, wret, wlow} = 3'h4;
        repeat (8) @(negedge core_clk);
        {sys_rst, trip} = 2'h0;
        check("state", 8'h00, st);
        frame(NB, MD);
        check("state", 8'h01, st);
        $display("test safe done");
        tally_and_finish();
    end
endmodule

//--- tb/ctlst_status_sva.sv
// Checker for the controller status bytes
`timescale 1ns/1ps
module ctlst_status_sva #(
    parameter int FRAME_BYTES = 67
) (
    input wire logic                   core_clk,
    input wire logic                   sys_rst,
    input wire logic                   spi_cs_n,
    input wire logic                   spi_miso_oe,
    input wire logic                   safe_state_trip,
    input wire ctlst_pkg::ctlst_byte_t controller_state,
    input wire ctlst_pkg::ctlst_byte_t controller_warnings,
    input wire logic                   frame_done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Cycles since safe trip; saturates so the lag of the trip is covered
    logic [1:0] safe_cnt;
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            safe_cnt <= 2'h0;
        else if ((safe_state_trip || safe_cnt != 2'h0) && safe_cnt != 2'h3)
            safe_cnt <= safe_cnt + 2'h1;
    end
    sequence cs_idle;
        spi_cs_n [*4];
    endsequence
    // ==========================================
    // Properties
    rst_clear_a: assert property ($fell(sys_rst) |->
        controller_state == 8'h00 && controller_warnings == 8'h00)
        else $error("status not clear after reset");
    spare_zero_a: assert property (controller_state[3:1] == 3'h0 &&
        controller_warnings[7:3] == 5'h00 && !controller_warnings[0])
        else $error("unassigned status bit set");
    fault_legal_a: assert property (controller_state[7:4] != 4'h1 &&
        controller_state[7:4] <= 4'h6) else $error("illegal fault code");
    state_hold_a: assert property ($changed(controller_state) |->
        $past(frame_done) || safe_state_trip || safe_cnt != 2'h0)
        else $error("state changed outside frame end");
    done_pulse_a: assert property (frame_done |=> !frame_done)
        else $error("frame_done longer than one cycle");
    done_cs_a: assert property (frame_done |->
        spi_cs_n && $past(spi_cs_n)) else $error("frame_done with cs low");
    oe_idle_a: assert property (cs_idle |-> !spi_miso_oe)
        else $error("miso driven while deselected");
    safe_quiet_a: assert property (safe_cnt == 2'h3 |->
        !spi_miso_oe && !controller_state[0] && !frame_done)
        else $error("exchange served in safe state");
    ready_clean_a: assert property ($past(frame_done) &&
        controller_state[0] |-> controller_state[7:4] == 4'h0)
        else $error("ready set with fault");
endmodule
bind ctlst_status ctlst_status_sva #(.FRAME_BYTES(FRAME_BYTES)) u_sva (
    .core_clk, .sys_rst, .spi_cs_n, .spi_miso_oe, .safe_state_trip,
    .controller_state, .controller_warnings, .frame_done);
